// *** rtl/cpb_pkg.sv ***
// Package: constants and types for code protection and boot select
package cpb_pkg;
   // Application and loader flash sizes in bytes
   localparam int APP_BYTES = 32768;
   localparam int LDR_BYTES = 4096;
   localparam int APP_AW = 15;
   localparam int LDR_AW = 12;
   // Protection register address inside the loader space seen by the programmer
   localparam logic [15:0] PROT_ADDR = 16'hffff;
   // Protection register bit positions
   localparam int LOCK_BIT = 0;
   localparam int TBL_INH_BIT = 1;
   localparam int ENC_BIT = 2;
   localparam int OSC_GAIN_BIT = 7;
   // Value after erase: all bits unprogrammed
   localparam logic [7:0] PROT_ERASED = 8'hff;
   localparam logic [7:0] FLASH_ERASED = 8'hff;
   // Programming commands
   typedef enum logic [1:0] {
      CPB_CMD_READ = 2'b00,
      CPB_CMD_PROG = 2'b01,
      CPB_CMD_ERASE = 2'b10,
      CPB_CMD_NONE = 2'b11
   } cpb_cmd_t;
   // Erase sweep states
   typedef enum logic [1:0] {
      CPB_ST_IDLE = 2'b00,
      CPB_ST_ERASE = 2'b01,
      CPB_ST_WAIT = 2'b10
   } cpb_state_t;
endpackage

// *** rtl/cpb_mem.sv ***
// Memory: single-port byte array with registered read data
`timescale 1ns/1ns
module cpb_mem #(
   parameter int AW = 15
) (
   // Clock
   input wire logic i_clk,
   // Access
   input wire logic i_we,
   input wire logic [AW-1:0] i_addr,
   input wire logic [7:0] i_wdata,
   output logic [7:0] o_rdata
);
   logic [7:0] mem [0:(1<<AW)-1];

   always_ff @(posedge i_clk) begin
      if (i_we) begin
         mem[i_addr] <= i_wdata;
      end
      o_rdata <= mem[i_addr];
   end
endmodule

// *** rtl/cpb_top.sv ***
// Code protection, boot selection and flash programming access
//
// Behaviour
// - Without a strap condition, boot from application flash.
// - In programming mode flash may be programmed and read back repeatedly.
// - Protection register reachable only in programming mode.
// - Protection register sits at ffff in the loader space.
// - Programmed protection bits never return to one by programming.
// - Protection bits return to one only in full-array erase.
// - Lock at zero refuses external reads of flash and protection register.
// - Inhibit zero: table reads from external code reach external memory only.
// - Table reads from internal code reach internal and external memory.
// - Inhibit one: table reads are not restricted.
// - Encryption enabled: port-0 data passes through the encoder.
// - Encryption enable cleared only by whole-chip erase.
// - Gain bit at zero halves the oscillator amplifier gain.
`timescale 1ns/1ns
module cpb_top #(
   parameter logic [7:0] ENC_KEY = 8'h5a
) (
   // Clock and reset
   input wire logic i_clk,
   input wire logic i_srst,
   // Boot straps, sampled at reset release
   input wire logic i_boot_strap_low,
   input wire logic i_boot_strap_high,
   input wire logic i_boot_strap_alt,
   output logic o_loader_boot_mode,
   // Programming port (address, data, strobes, read data one cycle later)
   input wire logic i_prog_mode,
   input wire logic i_prog_loader,
   input wire logic [15:0] i_prog_addr,
   input wire logic [7:0] i_prog_wdata,
   input wire logic i_prog_wr,
   input wire logic i_prog_rd,
   input wire logic i_prog_erase,
   output logic [7:0] o_prog_rdata,
   output logic o_prog_busy,
   // Code-table read from the core
   input wire logic i_tbl_req,
   input wire logic i_tbl_from_internal,
   input wire logic [15:0] i_tbl_addr,
   output logic o_tbl_internal,
   output logic [7:0] o_tbl_rdata,
   // Port 0 output data
   input wire logic [7:0] i_port0_data,
   output logic [7:0] o_port0_data,
   // Protection status
   output logic o_locked,
   output logic o_enc_enable,
   output logic o_osc_half_gain
);
   typedef struct packed {
      // Erase sweep state and address
      cpb_pkg::cpb_state_t st;
      logic [cpb_pkg::APP_AW-1:0] ptr;
      // Non-volatile protection byte; a feature is on when its bit is low
      logic [7:0] prot;
      // Boot choice and the flag that freezes it after the first edge
      logic boot_ldr;
      logic rst_seen;
      // Programmer read in flight
      logic rd_pend;
      logic rd_prot;
      logic rd_ldr;
      // Core table read in flight
      logic tbl_pend;
      logic tbl_ldr;
      // Port-0 output register
      logic [7:0] port0;
   } cpb_regs_t;

   // Protection byte starts erased at power-up; reset never touches it
   cpb_regs_t r = '{st: cpb_pkg::CPB_ST_IDLE, prot: cpb_pkg::PROT_ERASED, default: '0};
   cpb_regs_t next_r;

   logic [7:0] app_rdata;
   logic [7:0] ldr_rdata;
   logic app_we;
   logic ldr_we;
   logic [cpb_pkg::APP_AW-1:0] app_addr;
   logic [cpb_pkg::LDR_AW-1:0] ldr_addr;
   logic [7:0] mem_wdata;
   logic locked;
   logic prot_hit;
   logic tbl_int_ok;

   // Decoded requests and helpers
   cpb_pkg::cpb_cmd_t prog_cmd;
   logic [7:0] prot_after_wr;
   logic boot_pick;
   logic sweep_last;
   logic tbl_addr_internal;

   // Data paths
   logic [7:0] key_mask;
   logic [7:0] port0_coded;
   logic [7:0] prog_mem_rdata;
   logic [7:0] tbl_mem_rdata;
   logic prog_sel_prot;

   function automatic logic is_prot_addr(input logic ldr, input logic [15:0] a);
      is_prot_addr = ldr && (a == cpb_pkg::PROT_ADDR);
   endfunction

   // Programmer request decode; erase outranks the byte strobes
   function automatic cpb_pkg::cpb_cmd_t decode_cmd(
      input logic mode,
      input logic erase,
      input logic wr,
      input logic rd
   );
      decode_cmd = cpb_pkg::CPB_CMD_NONE;
      if (mode) begin
         if (erase) begin
            decode_cmd = cpb_pkg::CPB_CMD_ERASE;
         end else if (wr) begin
            decode_cmd = cpb_pkg::CPB_CMD_PROG;
         end else if (rd) begin
            decode_cmd = cpb_pkg::CPB_CMD_READ;
         end
      end
   endfunction

   // Loader boot when both port-2 straps are low or the alternate strap is low
   function automatic logic strap_boot(
      input logic lo,
      input logic hi,
      input logic alt
   );
      strap_boot = (~hi & ~lo) | ~alt;
   endfunction

   // Ordinary programming can only pull bits low
   function automatic logic [7:0] prot_program(
      input logic [7:0] old,
      input logic [7:0] wdata
   );
      prot_program = old & wdata;
   endfunction

   // A protection feature is active when its bit has been programmed low
   function automatic logic prot_active(input logic [7:0] p, input int pos);
      prot_active = ~p[pos];
   endfunction

   // Internal flash occupies the lower half of the code space
   function automatic logic is_internal_addr(input logic [15:0] a);
      is_internal_addr = (a[15] == 1'b0);
   endfunction

   // One byte picked from the loader or the application array
   function automatic logic [7:0] pick_byte(
      input logic ldr,
      input logic [7:0] ldr_byte,
      input logic [7:0] app_byte
   );
      pick_byte = ldr ? ldr_byte : app_byte;
   endfunction

   assign locked = prot_active(r.prot, cpb_pkg::LOCK_BIT);
   assign prot_hit = is_prot_addr(i_prog_loader, i_prog_addr);
   assign prog_cmd = decode_cmd(i_prog_mode, i_prog_erase, i_prog_wr, i_prog_rd);
   assign prot_after_wr = prot_program(r.prot, i_prog_wdata);
   assign boot_pick = strap_boot(i_boot_strap_low, i_boot_strap_high, i_boot_strap_alt);
   assign sweep_last = &r.ptr;
   assign tbl_addr_internal = is_internal_addr(i_tbl_addr);
   // Key applied only while the encryption bit is programmed low
   assign key_mask = r.prot[cpb_pkg::ENC_BIT] ? 8'h00 : ENC_KEY;

   // Per-bit mask keeps each port-0 lane independent of the others
   genvar gi;
   generate
      for (gi = 0; gi < 8; gi++) begin : g_enc
         assign port0_coded[gi] = i_port0_data[gi] ^ key_mask[gi];
      end
   endgenerate

   // Internal flash reachable from internal code always; from external code only when not inhibited
   assign tbl_int_ok = i_tbl_from_internal
      || r.prot[cpb_pkg::TBL_INH_BIT];

   always_comb begin
      next_r = r;
      app_we = 1'b0;
      ldr_we = 1'b0;
      app_addr = i_prog_addr[cpb_pkg::APP_AW-1:0];
      ldr_addr = i_prog_addr[cpb_pkg::LDR_AW-1:0];
      mem_wdata = i_prog_wdata;
      next_r.rd_pend = 1'b0;
      next_r.tbl_pend = 1'b0;

      // Straps caught on the first clock after reset release only, so
      // buttons released after power-up do not change the boot source
      if (!r.rst_seen) begin
         next_r.rst_seen = 1'b1;
         next_r.boot_ldr = boot_pick;
      end

      unique case (r.st)
         cpb_pkg::CPB_ST_IDLE: begin
            unique case (prog_cmd)
               cpb_pkg::CPB_CMD_ERASE: begin
                  next_r.st = cpb_pkg::CPB_ST_ERASE;
                  next_r.ptr = '0;
               end
               cpb_pkg::CPB_CMD_PROG: begin
                  if (prot_hit) begin
                     next_r.prot = prot_after_wr;
                  end else if (i_prog_loader) begin
                     ldr_we = 1'b1;
                  end else begin
                     app_we = 1'b1;
                  end
               end
               cpb_pkg::CPB_CMD_READ: begin
                  if (!locked) begin
                     next_r.rd_pend = 1'b1;
                     next_r.rd_prot = prot_hit;
                     next_r.rd_ldr = i_prog_loader;
                  end
               end
               cpb_pkg::CPB_CMD_NONE: begin
               end
            endcase
            // Table reads only while the programmer is away: the arrays have one port
            if (!i_prog_mode && i_tbl_req) begin
               next_r.tbl_pend = 1'b1;
               next_r.tbl_ldr = r.boot_ldr;
               app_addr = i_tbl_addr[cpb_pkg::APP_AW-1:0];
               ldr_addr = i_tbl_addr[cpb_pkg::LDR_AW-1:0];
            end
         end

         cpb_pkg::CPB_ST_ERASE: begin
            // Sweep both arrays; loader is smaller so its writes wrap harmlessly
            app_we = 1'b1;
            ldr_we = 1'b1;
            app_addr = r.ptr;
            ldr_addr = r.ptr[cpb_pkg::LDR_AW-1:0];
            mem_wdata = cpb_pkg::FLASH_ERASED;
            next_r.ptr = r.ptr + 1'b1;
            if (sweep_last) begin
               next_r.st = cpb_pkg::CPB_ST_WAIT;
               next_r.prot = cpb_pkg::PROT_ERASED;
            end
         end

         cpb_pkg::CPB_ST_WAIT: begin
            // Hold until the erase request drops, so one request erases once
            if (!i_prog_erase) begin
               next_r.st = cpb_pkg::CPB_ST_IDLE;
            end
         end

         default: begin
            next_r.st = cpb_pkg::CPB_ST_IDLE;
         end
      endcase

      // Port 0 data registered, encoded when enabled
      next_r.port0 = port0_coded;
   end

   // Single register stage for the whole state struct
   always_ff @(posedge i_clk) begin
      if (i_srst) begin
         r.st <= cpb_pkg::CPB_ST_IDLE;
         r.ptr <= '0;
         r.boot_ldr <= 1'b0;
         r.rst_seen <= 1'b0;
         r.rd_pend <= 1'b0;
         r.rd_prot <= 1'b0;
         r.rd_ldr <= 1'b0;
         r.tbl_pend <= 1'b0;
         r.tbl_ldr <= 1'b0;
         r.port0 <= 8'h00;
         // Protection register is non-volatile: reset leaves it alone
         r.prot <= r.prot;
      end else begin
         r <= next_r;
      end
   end

   // Two single-port arrays; the erase sweep writes both in one pass
   cpb_mem #(
      .AW(cpb_pkg::APP_AW)
   ) u_app (
      .i_clk(i_clk),
      .i_we(app_we),
      .i_addr(app_addr),
      .i_wdata(mem_wdata),
      .o_rdata(app_rdata)
   );

   cpb_mem #(
      .AW(cpb_pkg::LDR_AW)
   ) u_ldr (
      .i_clk(i_clk),
      .i_we(ldr_we),
      .i_addr(ldr_addr),
      .i_wdata(mem_wdata),
      .o_rdata(ldr_rdata)
   );

   assign prog_mem_rdata = pick_byte(r.rd_ldr, ldr_rdata, app_rdata);
   assign tbl_mem_rdata = pick_byte(r.tbl_ldr, ldr_rdata, app_rdata);
   assign prog_sel_prot = r.rd_pend && r.rd_prot;

   // Read data valid only in the cycle after the strobe; zero otherwise
   always_comb begin
      o_prog_rdata = 8'h00;
      if (prog_sel_prot) begin
         o_prog_rdata = r.prot;
      end else if (r.rd_pend) begin
         o_prog_rdata = prog_mem_rdata;
      end
   end

   // Gating uses the live address, so the core holds it for both cycles
   always_comb begin
      o_tbl_rdata = 8'h00;
      if (r.tbl_pend && o_tbl_internal) begin
         o_tbl_rdata = tbl_mem_rdata;
      end
   end

   // Status outputs are active high; the protection flags are set while their bit is programmed low
   assign o_tbl_internal = tbl_int_ok && tbl_addr_internal;
   assign o_prog_busy = (r.st != cpb_pkg::CPB_ST_IDLE);
   assign o_loader_boot_mode = r.boot_ldr;
   assign o_port0_data = r.port0;
   assign o_locked = locked;
   assign o_enc_enable = prot_active(r.prot, cpb_pkg::ENC_BIT);
   assign o_osc_half_gain = prot_active(r.prot, cpb_pkg::OSC_GAIN_BIT);
endmodule

// *** verif/cpb_top_assertions.sv ***
// Assertion checker for the protection and boot ports
`timescale 1ns/1ns
module cpb_top_assertions #(
   parameter logic [7:0] ENC_KEY = 8'h5a
) (
   input wire logic i_clk, i_srst, i_boot_strap_low, i_boot_strap_high, i_boot_strap_alt,
   input wire logic o_loader_boot_mode, i_prog_mode, i_prog_rd, i_prog_erase, o_prog_busy,
   input wire logic [15:0] i_tbl_addr,
   input wire logic [7:0] o_prog_rdata, i_port0_data, o_port0_data,
   input wire logic i_tbl_req, i_tbl_from_internal, o_tbl_internal, o_locked, o_enc_enable, o_osc_half_gain
);
   default clocking @(posedge i_clk); endclocking
   default disable iff (i_srst);
   sequence s_release; $past(i_srst) && !i_srst; endsequence
   sequence s_sweep_end; $fell(o_prog_busy); endsequence
   AST_BOOT:
      assert property (s_release |=> o_loader_boot_mode ==
         (!$past(i_boot_strap_alt) || !($past(i_boot_strap_high) || $past(i_boot_strap_low)))) else $error("boot");
   AST_PORT0:
      assert property (!$past(i_srst) |-> o_port0_data ==
         ($past(i_port0_data) ^ ($past(o_enc_enable) ? ENC_KEY : 8'h00))) else $error("port0");
   AST_LOCK_READ:
      assert property (i_prog_rd && o_locked |=> o_prog_rdata == 8'h00) else $error("locked read");
   AST_NO_PROG:
      assert property (i_prog_rd && !i_prog_mode |=> o_prog_rdata == 8'h00) else $error("read outside mode");
   AST_KEEP:
      assert property ($fell(o_locked) || $fell(o_osc_half_gain) |-> $past(o_prog_busy)) else $error("bit undone");
   AST_ENC_KEEP:
      assert property ($fell(o_enc_enable) |-> $past(o_prog_busy)) else $error("encryption undone");
   AST_ERASED:
      assert property (s_sweep_end |-> !o_locked && !o_enc_enable && !o_osc_half_gain) else $error("erase");
   AST_ERASE_GO:
      assert property (i_prog_mode && $rose(i_prog_erase) && !o_prog_busy |=> o_prog_busy) else $error("sweep");
   AST_TBL_INT:
      assert property (i_tbl_req && i_tbl_from_internal && !i_prog_mode && !i_tbl_addr[15] |-> o_tbl_internal)
         else $error("table internal");
   AST_TBL_EXT:
      assert property (i_tbl_req && i_tbl_addr[15] |-> !o_tbl_internal) else $error("table external");
endmodule

bind cpb_top cpb_top_assertions #(.ENC_KEY(ENC_KEY)) u_chk (.i_clk, .i_srst, .i_boot_strap_low,
   .i_boot_strap_high, .i_boot_strap_alt, .o_loader_boot_mode, .i_prog_mode, .i_prog_rd, .i_prog_erase,
   .o_prog_busy, .i_tbl_addr, .o_prog_rdata, .i_port0_data, .o_port0_data, .i_tbl_req,
   .i_tbl_from_internal, .o_tbl_internal, .o_locked, .o_enc_enable, .o_osc_half_gain);

// *** verif/cpb_ext_mem.sv ***
// External program memory answering code-table reads
`timescale 1ns/1ns
module cpb_ext_mem (
   input wire logic i_clk,
   input wire logic i_req,
   input wire logic [15:0] i_addr,
   output logic [7:0] o_data
);
   initial o_data = 8'h00;
   // Idle bus toggles so a stale byte never passes for an answer
   always @(posedge i_clk) begin
      o_data <= i_req ? (i_addr[7:0] ^ 8'hc3) : ~o_data;
   end
endmodule

// *** verif/cpb_top_tb_top.sv ***
// Testbench for code protection and boot selection
`timescale 1ns/1ns
module cpb_top_tb_top;
   localparam logic [7:0] KEY = 8'h5a;
   localparam logic [15:0] PA = cpb_pkg::PROT_ADDR;
   logic i_clk = 0, i_srst = 1, s_lo = 1, s_hi = 1, s_alt = 1, pm = 0, pl = 0, wr = 0, rd = 0, er = 0;
   logic treq = 0, tint = 0, boot, busy, tin, lk, enc, half;
   logic [15:0] pa = 0, ta = 0;
   logic [7:0] wd = 0, p0 = 0, rdat, tdat, p0o, xdat;
   int num_errors = 0, tests_run = 0;
   always #4 i_clk = ~i_clk;
   cpb_top #(.ENC_KEY(KEY)) DUT (.i_clk, .i_srst, .i_boot_strap_low(s_lo), .i_boot_strap_high(s_hi),
      .i_boot_strap_alt(s_alt), .o_loader_boot_mode(boot), .i_prog_mode(pm), .i_prog_loader(pl),
      .i_prog_addr(pa), .i_prog_wdata(wd), .i_prog_wr(wr), .i_prog_rd(rd), .i_prog_erase(er),
      .o_prog_rdata(rdat), .o_prog_busy(busy), .i_tbl_req(treq), .i_tbl_from_internal(tint),
      .i_tbl_addr(ta), .o_tbl_internal(tin), .o_tbl_rdata(tdat), .i_port0_data(p0), .o_port0_data(p0o),
      .o_locked(lk), .o_enc_enable(enc), .o_osc_half_gain(half));
   cpb_ext_mem u_ext (.i_clk, .i_req(treq), .i_addr(ta), .o_data(xdat));
   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      tests_run++;
      if (got !== exp) begin
         num_errors++;
         $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic wr_b(input logic l, input logic [15:0] a, input logic [7:0] d);
      @(posedge i_clk);
      pl <= l;
      pa <= a;
      wd <= d;
      wr <= 1;
      @(posedge i_clk);
      wr <= 0;
   endtask
   task automatic rd_b(input logic l, input logic [15:0] a, input logic [7:0] e);
      @(posedge i_clk);
      pl <= l;
      pa <= a;
      rd <= 1;
      @(posedge i_clk);
      rd <= 0;
      #1 chk(rdat, e);
   endtask
   task automatic tbl(input logic fi, input logic [15:0] a, input logic ei, input logic [7:0] ed);
      @(posedge i_clk);
      tint <= fi;
      ta <= a;
      treq <= 1;
      #1 chk(tin, ei);
      @(posedge i_clk);
      treq <= 0;
      #1 chk(tin ? tdat : xdat, ed);
      @(posedge i_clk);
   endtask
   task automatic wait_busy(input logic v, input int n);
      for (int k = 0; k < n && busy !== v; k++) begin
         @(posedge i_clk);
         #1;
      end
      if (busy !== v) begin
         num_errors++;
         $display("CHECK FAILED at %0t: busy wait ran out", $time);
         tally_and_finish;
      end
   endtask
   task automatic tally_and_finish;
      $display("Checks %0d, mismatches %0d", tests_run, num_errors);
      if (num_errors == 0 && tests_run > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask
   initial begin
      repeat (16) @(posedge i_clk);
      for (int s = 0; s < 8; s++) begin
         @(posedge i_clk);
         {s_alt, s_hi, s_lo} <= s[2:0];
         i_srst <= 1;
         @(posedge i_clk);
         i_srst <= 0;
         repeat (3) @(posedge i_clk);
         chk(boot, !s[2] || s[1:0] == 2'b00);
      end
      $display("Boot strap test done");
      pm <= 1;
      rd_b(1, PA, 8'hff);
      wr_b(0, 16'h0010, 8'ha5);
      wr_b(1, 16'h0020, 8'h3c);
      rd_b(0, 16'h0010, 8'ha5);
      rd_b(1, 16'h0020, 8'h3c);
      wr_b(1, PA, 8'h79);
      wr_b(1, PA, 8'hff);
      rd_b(1, PA, 8'h79);
      chk({lk, enc, half}, 8'h03);
      p0 <= 8'h3c;
      repeat (2) @(posedge i_clk);
      chk(p0o, 8'h3c ^ KEY);
      pm <= 0;
      rd_b(1, PA, 8'h00);
      tbl(0, 16'h0010, 0, 8'hd3);
      tbl(1, 16'h0010, 1, 8'ha5);
      tbl(1, 16'h8010, 0, 8'hd3);
      $display("Protection bits test done");
      pm <= 1;
      // Lock goes last, once the image has been read back
      wr_b(1, PA, 8'h78);
      rd_b(0, 16'h0010, 8'h00);
      rd_b(1, PA, 8'h00);
      @(posedge i_clk);
      er <= 1;
      wait_busy(1, 4);
      repeat (32800) @(posedge i_clk);
      er <= 0;
      wait_busy(0, 4);
      chk({lk, enc, half}, 8'h00);
      rd_b(1, PA, 8'hff);
      rd_b(0, 16'h0010, 8'hff);
      pm <= 0;
      tbl(0, 16'h0010, 1, 8'hff);
      $display("Lock and erase test done");
      tally_and_finish;
   end
endmodule
